// ===== core/qdac_pkg.sv
/*
  Shared constants for the quad DAC parallel write link: bus widths, control
  write codes, field positions, reset values and host register map.
  Assumes a single 25 MHz clock shared by both ends.
*/
package qdac_pkg;

  localparam int CHANNELS = 4;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 10;
  localparam int MAIN_W = 10;
  localparam int SUB_W = 8;

  // System control word fields.
  localparam int SYS_TWOS_BIT = 5;
  localparam logic [DATA_W-1:0] SYS_CFG_TWOS = 10'h020;
  // Channel control word fields.
  localparam int CH_MAIN_SUB_BIT = 7;
  localparam int CH_MX0_BIT = 0;
  localparam int CH_MX1_BIT = 1;
  localparam logic [DATA_W-1:0] CH_CFG_MAIN = 10'h011;
  localparam logic [DATA_W-1:0] CH_CFG_SUB = 10'h091;

  // Reset values: offset binary, main routing, supply half bias.
  localparam logic RST_TWOS = 1'b0;
  localparam logic RST_SUB_SEL = 1'b0;
  localparam logic [1:0] RST_BIAS_SEL = 2'h0;
  localparam logic [MAIN_W-1:0] RST_MAIN = 10'h000;
  localparam logic [SUB_W-1:0] RST_SUB = 8'h00;
  localparam logic [MAIN_W-1:0] MAIN_MIDPOINT_OB = 10'h200;

  // Host timing in pclk cycles: write strobe low width and load setup.
  localparam int WR_LOW_CYCLES = 2;
  localparam int LOAD_SETUP_CYCLES = 2;

  // Host APB register map (byte addresses).
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_LOAD = 8'h08;
  localparam int CMD_DATA_LSB = 0;
  localparam int CMD_ADDR_LSB = 10;
  localparam int CMD_MODE_BIT = 13;
  localparam int CMD_LOADLOW_BIT = 14;

endpackage : qdac_pkg

// ===== core/qdac_if.sv
/*
  Parallel write link between host and quad DAC.
  Assumes both ends run on the same pclk.
*/
`timescale 1ns/1ps
interface qdac_if;
  logic [2:0] addr;
  logic [9:0] data;
  logic mode;
  logic wr_n;
  logic load_outputs_strobe_n;

  modport dev (
    input addr,
    input data,
    input mode,
    input wr_n,
    input load_outputs_strobe_n
  );
  modport host (
    output addr,
    output data,
    output mode,
    output wr_n,
    output load_outputs_strobe_n
  );
endinterface : qdac_if

// ===== core/qdac_device.sv
/*
  Quad DAC digital core: control registers, per channel holding registers and
  output registers updated by the load strobe.
  Assumes link pins come from the host and are synchronised here.
*/
// Overview of operation
// - Load strobe copies all data registers together
// - Sample load at write rise; low updates
// - Host holds load low or data-timed
// - Load high at sample defers update
// - Host waits setup before asynchronous load
// - Four channels, 10-bit main, 8-bit sub
// - One coding choice for every channel
// - Offset binary coding after reset
// - Twos complement main spans -512 to 511
// - Twos complement sub spans -128 to 127
// - Mode low system write ignores address
// - Code 011 selects bias, main routing
// - Code 091 selects bias, sub routing
// - Mode low address picks channel control
// - Mode high stores to addressed channel
// - Twos main 200 lowest, 1FF highest
// - Offset binary main 512 is midpoint
// - Routing bit 0 main, 1 sub
`timescale 1ns/1ps
module qdac_device
  import qdac_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  qdac_if.dev link,
  output logic twos_mode,
  output logic [CHANNELS*MAIN_W-1:0] main_out,
  output logic [CHANNELS*SUB_W-1:0] sub_out,
  output logic [CHANNELS*MAIN_W-1:0] main_offset_out,
  output logic [CHANNELS*2-1:0] bias_sel,
  output logic update_pulse
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [15:0] sync1_q;
  logic [15:0] sync2_q;
  logic wr_prev_q;
  logic load_prev_q;
  logic deferred_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q <= 16'hc000;
      sync2_q <= 16'hc000;
    end
    else
    begin
      sync1_q <= {link.wr_n, link.load_outputs_strobe_n, link.mode, link.addr, link.data};
      sync2_q <= sync1_q;
    end
  end

  logic wr_n_s;
  logic load_n_s;
  logic mode_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] data_s;
  assign {wr_n_s, load_n_s, mode_s, addr_s, data_s} = sync2_q;

  // Data is captured at the synchronised write rise; the host holds data
  // across the rise so the synchronised copy is still stable here.
  logic wr_rise;
  logic load_fall;
  assign wr_rise = wr_n_s && !wr_prev_q;
  assign load_fall = !load_n_s && load_prev_q;

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  logic twos_q;
  logic sub_sel_q [CHANNELS];
  logic [1:0] bias_q [CHANNELS];

  // A mode-low write with bit 4 set is a channel write (011/091 carry it);
  // otherwise it is the system control write with address ignored.
  function automatic logic is_chan_write(input logic [DATA_W-1:0] d);
    return d[4];
  endfunction : is_chan_write

  // Only a system control write may touch the coding, so that a channel
  // write cannot silently drop the part back to offset binary.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      twos_q <= RST_TWOS;
    else if (wr_rise && !mode_s && !is_chan_write(data_s))
      twos_q <= data_s[SYS_TWOS_BIT];
  end

  // ----------------------------------------------------------------------
  // Per channel holding and output registers
  // ----------------------------------------------------------------------
  logic [MAIN_W-1:0] main_hold_q [CHANNELS];
  logic [SUB_W-1:0] sub_hold_q [CHANNELS];
  logic [MAIN_W-1:0] main_q [CHANNELS];
  logic [SUB_W-1:0] sub_q [CHANNELS];
  logic do_update;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_prev_q <= 1'b1;
      load_prev_q <= 1'b1;
      deferred_q <= 1'b0;
    end
    else
    begin
      wr_prev_q <= wr_n_s;
      load_prev_q <= load_n_s;
      if (wr_rise && mode_s)
        deferred_q <= load_n_s;
      else if (load_fall)
        deferred_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Update control
  // ----------------------------------------------------------------------
  // The synchronous update waits one edge so that the holding register
  // already carries the word written at the same rise; copying at that very
  // edge would move the previous word to the output instead.
  logic sync_upd_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_upd_q <= 1'b0;
    else
      sync_upd_q <= wr_rise && mode_s && !load_n_s;
  end

  // Async update on a later load fall after a write that saw load high.
  assign do_update = sync_upd_q || (load_fall && deferred_q);
  assign update_pulse = do_update;

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++)
    begin : g_ch
      logic hit;
      assign hit = wr_rise && (addr_s == ADDR_W'(ch));

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          sub_sel_q[ch] <= RST_SUB_SEL;
          bias_q[ch] <= RST_BIAS_SEL;
        end
        else if (hit && !mode_s && is_chan_write(data_s))
        begin
          sub_sel_q[ch] <= data_s[CH_MAIN_SUB_BIT];
          bias_q[ch] <= {data_s[CH_MX1_BIT], data_s[CH_MX0_BIT]};
        end
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          main_hold_q[ch] <= RST_MAIN;
          sub_hold_q[ch] <= RST_SUB;
        end
        else if (hit && mode_s)
        begin
          if (sub_sel_q[ch])
            sub_hold_q[ch] <= data_s[SUB_W-1:0];
          else
            main_hold_q[ch] <= data_s;
        end
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          main_q[ch] <= RST_MAIN;
          sub_q[ch] <= RST_SUB;
        end
        else if (do_update)
        begin
          main_q[ch] <= main_hold_q[ch];
          sub_q[ch] <= sub_hold_q[ch];
        end
      end

      // Offset binary view of the main code: twos complement flips the MSB
      // so 200 is lowest and 1FF highest; offset binary 512 sits at bias.
      assign main_offset_out[ch*MAIN_W +: MAIN_W] = twos_q
        ? (main_q[ch] ^ MAIN_MIDPOINT_OB) : main_q[ch];
      assign main_out[ch*MAIN_W +: MAIN_W] = main_q[ch];
      // Sub code is signed in twos complement; zero means no offset.
      assign sub_out[ch*SUB_W +: SUB_W] = sub_q[ch];
      assign bias_sel[ch*2 +: 2] = bias_q[ch];
    end
  endgenerate

  assign twos_mode = twos_q;

endmodule : qdac_device

// ===== core/qdac_host.sv
/*
  Host controller: APB slave that takes a command word and drives one
  parallel write, plus an asynchronous load request.
  Assumes the device samples pins through two flip-flops on pclk.
*/
`timescale 1ns/1ps
module qdac_host
  import qdac_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  qdac_if.host link
);

  typedef enum logic [2:0] {IDLE, SETUP, STROBE, HOLD, LSETUP, LPULSE} qdac_state_e;
  qdac_state_e state_q;
  logic [2:0] cnt_q;
  logic [DATA_W-1:0] data_q;
  logic [ADDR_W-1:0] addr_q;
  logic mode_q;
  logic loadlow_q;
  logic busy;
  logic acc;

  assign busy = (state_q != IDLE);
  assign acc = psel && penable;
  assign pready = 1'b1;
  assign pslverr = acc && !(paddr == REG_CMD || paddr == REG_STATUS || paddr == REG_LOAD);

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // Commands written while busy are dropped; software polls status first.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= IDLE;
      cnt_q <= 3'h0;
      data_q <= '0;
      addr_q <= '0;
      mode_q <= 1'b0;
      loadlow_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_q + 3'h1;
      unique case (state_q)
        IDLE:
        begin
          cnt_q <= 3'h0;
          if (acc && pwrite && paddr == REG_CMD)
          begin
            data_q <= pwdata[CMD_DATA_LSB +: DATA_W];
            addr_q <= pwdata[CMD_ADDR_LSB +: ADDR_W];
            mode_q <= pwdata[CMD_MODE_BIT];
            loadlow_q <= pwdata[CMD_LOADLOW_BIT];
            state_q <= SETUP;
          end
          else if (acc && pwrite && paddr == REG_LOAD)
            state_q <= LSETUP;
        end
        SETUP:
        begin
          cnt_q <= 3'h0;
          state_q <= STROBE;
        end
        STROBE:
          if (cnt_q == 3'(WR_LOW_CYCLES - 1))
          begin
            cnt_q <= 3'h0;
            state_q <= HOLD;
          end
        HOLD:
          // Pins stay put while the device's synchronisers see the rise.
          if (cnt_q == 3'h3)
          begin
            loadlow_q <= 1'b0;
            state_q <= IDLE;
          end
        LSETUP:
          if (cnt_q == 3'(LOAD_SETUP_CYCLES - 1))
          begin
            cnt_q <= 3'h0;
            state_q <= LPULSE;
          end
        LPULSE:
          if (cnt_q == 3'h3)
            state_q <= IDLE;
      endcase
    end
  end

  assign link.data = data_q;
  assign link.addr = addr_q;
  assign link.mode = mode_q;
  assign link.wr_n = (state_q != STROBE);
  assign link.load_outputs_strobe_n = !(loadlow_q || state_q == LPULSE);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= (paddr == REG_STATUS) ? {31'h0, busy} : 32'h0000_0000;
  end

endmodule : qdac_host

// ===== test/qdac_link_sva.sv
/*
  Checker for the parallel write link between host and quad DAC.
  Assumes one pclk domain and the link signals wired in as plain inputs.
*/
`timescale 1ns/1ps
module qdac_link_sva
  import qdac_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] addr,
  input wire logic [9:0] data,
  input wire logic mode,
  input wire logic wr_n,
  input wire logic load_outputs_strobe_n
);
  // ----------------------------------------
  // Strobe shapes
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_wr_tail;
    !wr_n [*2] ##1 wr_n;
  endsequence

  sequence s_load_pulse;
    !load_outputs_strobe_n [*4] ##1 load_outputs_strobe_n;
  endsequence

  // Synchronous mode: load falls with the data setup and stays low through
  // the write strobe and the pin hold, timed like the data pins.
  sequence s_sync_load;
    (!load_outputs_strobe_n && wr_n) ##1 (!load_outputs_strobe_n && !wr_n) [*2]
      ##1 (!load_outputs_strobe_n && wr_n) [*4] ##1 load_outputs_strobe_n;
  endsequence

  chk_wr_low_width: assert property ($fell(wr_n) |-> s_wr_tail)
    else $error("write strobe low width wrong");
  chk_wr_pins_setup: assert property (!wr_n |-> $stable({addr, data, mode}))
    else $error("link pins moved during write strobe");
  chk_load_data_timed: assert property (!wr_n |-> $stable(load_outputs_strobe_n))
    else $error("load strobe moved during write strobe");
  chk_wr_pins_hold: assert property ($rose(wr_n) |-> $stable({addr, data, mode}) [*4])
    else $error("link pins not held after write");
  chk_wr_gap_min: assert property ($rose(wr_n) |-> wr_n [*5])
    else $error("writes too close together");
  chk_load_pulse_width: assert property ($fell(load_outputs_strobe_n) |-> (s_load_pulse or s_sync_load))
    else $error("load strobe low width wrong");
  chk_load_setup_gap: assert property ($rose(wr_n) && load_outputs_strobe_n
    |-> load_outputs_strobe_n [*3])
    else $error("async load too soon after write");
  chk_load_no_overlap: assert property ($fell(load_outputs_strobe_n) |-> wr_n)
    else $error("load strobe fell inside write strobe");
  cov_async_load: cover property ($rose(wr_n) && load_outputs_strobe_n);
endmodule : qdac_link_sva

// ===== test/quad_dac_load_and_coding_tb.sv
/*
  Self-checking bench: APB host controller driving the quad DAC core.
  Assumes the host answers APB with no wait states and reports busy in STATUS.
*/
`timescale 1ns/1ps
module quad_dac_load_and_coding_tb
  import qdac_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic twos_mode;
  logic [39:0] main_out;
  logic [31:0] sub_out;
  logic [39:0] main_offset_out;
  logic [7:0] bias_sel;
  logic update_pulse;
  logic [31:0] rd_q;
  logic err_q;
  int bad_count = 0;
  int checks_done = 0;
  int upd_count = 0;

  always #20 pclk = ~pclk;

  // Counts output updates so that stray or missing load events show up.
  always @(posedge pclk)
  begin
    if (update_pulse === 1'b1)
      upd_count <= upd_count + 1;
  end

  qdac_if link ();
  qdac_host i_qdac_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  qdac_device i_qdac_device (.pclk(pclk), .presetn(presetn), .link(link),
    .twos_mode(twos_mode), .main_out(main_out), .sub_out(sub_out),
    .main_offset_out(main_offset_out), .bias_sel(bias_sel), .update_pulse(update_pulse));
  qdac_link_sva i_qdac_link_sva (.pclk(pclk), .presetn(presetn), .addr(link.addr),
    .data(link.data), .mode(link.mode), .wr_n(link.wr_n),
    .load_outputs_strobe_n(link.load_outputs_strobe_n));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic complete_run();
    if (bad_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Entered just after a rising edge; leaves one edge after release.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      bad_count++;
      complete_run();
    end
    @(posedge pclk);
  endtask : apb

  // The extra cycles cover the device's two-flop pin synchroniser.
  task automatic wait_idle();
    int n;
    n = 0;
    do
    begin
      apb(1'b0, REG_STATUS, 32'h0);
      n++;
    end
    while (rd_q[0] !== 1'b0 && n < 50);
    if (n >= 50)
    begin
      bad_count++;
      complete_run();
    end
    repeat (8) @(posedge pclk);
  endtask : wait_idle

  task automatic send(input logic ll, input logic md, input logic [2:0] a,
    input logic [9:0] d);
    wait_idle();
    apb(1'b1, REG_CMD, 32'({ll, md, a, d}));
    wait_idle();
  endtask : send

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(40'(twos_mode), 40'h0);
    chk(main_out, 40'h0);
    chk(40'({sub_out, bias_sel}), 40'h0);
    apb(1'b0, 8'h0c, 32'h0);
    chk(40'(err_q), 40'h1);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(40'({err_q, rd_q[0]}), 40'h0);
    send(1'b0, 1'b0, 3'h1, CH_CFG_MAIN);
    chk(40'(bias_sel), 40'h04);
    send(1'b1, 1'b1, 3'h1, 10'h155);
    chk(main_out, 40'h0000055400);
    chk(main_offset_out, 40'h0000055400);
    send(1'b0, 1'b1, 3'h2, 10'h2aa);
    send(1'b0, 1'b1, 3'h3, 10'h3ff);
    chk(main_out, 40'h0000055400);
    chk(40'(upd_count), 40'h1);
    apb(1'b1, REG_LOAD, 32'h0);
    wait_idle();
    chk(main_out[39:20], {10'h3ff, 10'h2aa});
    send(1'b0, 1'b0, 3'h0, CH_CFG_SUB);
    chk(40'(bias_sel), 40'h05);
    send(1'b1, 1'b1, 3'h0, 10'h080);
    chk(40'(sub_out), 40'h80);
    chk(40'(main_out[9:0]), 40'h0);
    send(1'b1, 1'b1, 3'h0, 10'h07f);
    chk(40'(sub_out), 40'h7f);
    send(1'b0, 1'b0, 3'h5, SYS_CFG_TWOS);
    chk(40'({twos_mode, bias_sel}), 40'h105);
    chk(40'(main_offset_out[39:30]), 40'h1ff);
    send(1'b0, 1'b0, 3'h2, CH_CFG_MAIN);
    chk(40'(twos_mode), 40'h1);
    send(1'b1, 1'b1, 3'h1, 10'h200);
    chk(40'(main_offset_out[19:10]), 40'h000);
    send(1'b1, 1'b1, 3'h1, 10'h1ff);
    chk(40'(main_offset_out[19:10]), 40'h3ff);
    chk(40'(upd_count), 40'h6);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(40'({twos_mode, bias_sel}), 40'h0);
    chk(main_out, 40'h0);
    complete_run();
  end
endmodule : quad_dac_load_and_coding_tb
